// ==== mfi_decoder.v ====
// Multi-function input decoder with APB register access.
`include "mfi_defs.vh"
module mfi_decoder (
	// Clock and control
	input wire i_ref_clk,
	input wire i_srst,
	input wire i_ce,
	// APB slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [7:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// Contacts and panel
	input wire [5:0] i_contacts,
	input wire i_panel_lr_key,
	input wire i_panel_run,
	input wire i_remote_run,
	input wire i_stop_cmd,
	// Drive state
	input wire i_running,
	input wire [15:0] i_out_freq,
	input wire [15:0] i_nv_freq,
	// Source selection
	output reg o_local_mode,
	output reg o_ref_from_panel,
	output reg o_run_from_panel,
	output reg o_use_option_ref,
	output reg o_run,
	// Output blocking
	output reg o_output_block,
	output reg o_speed_search,
	output reg [15:0] o_retained_freq,
	output reg [7:0] o_volt_scale,
	// Ramp hold
	output reg o_ramp_hold,
	output reg o_hold_load,
	output reg [15:0] o_hold_freq,
	output reg o_nv_write,
	output reg [15:0] o_nv_data,
	// Messages
	output reg o_setting_conflict_error,
	output reg o_overheat_warning_message,
	// Other decoded functions
	output reg o_three_wire,
	output reg [3:0] o_step_ref,
	output reg [1:0] o_accel_sel,
	output reg o_fast_stop,
	output reg o_jog_fwd,
	output reg o_jog_rev
);
	reg [7:0] sel_reg [0:5];
	reg [31:0] ctrl_reg;
	reg lr_in_reg;
	reg opt_reg;
	reg run_block_reg;
	reg blk_d_reg;
	reg hold_d_reg;
	reg run_d_reg;
	wire [5:0] lvl;
	wire [47:0] sels;
	wire [7:0] vscale;
	wire vbusy;
	genvar gi;

	// True when any selector carries the code.
	function asg;
		input [47:0] s;
		input [7:0] c;
		integer k;
		begin
			asg = 1'b0;
			for (k = 0; k < 6; k = k + 1) begin
				if (s[8*k +: 8] == c) begin
					asg = 1'b1;
				end
			end
		end
	endfunction

	// True when an input carrying the code is on.
	function on;
		input [47:0] s;
		input [5:0] l;
		input [7:0] c;
		integer k;
		begin
			on = 1'b0;
			for (k = 0; k < 6; k = k + 1) begin
				if (s[8*k +: 8] == c && l[k]) begin
					on = 1'b1;
				end
			end
		end
	endfunction

	// True when an input carrying the code is off.
	function off;
		input [47:0] s;
		input [5:0] l;
		input [7:0] c;
		integer k;
		begin
			off = 1'b0;
			for (k = 0; k < 6; k = k + 1) begin
				if (s[8*k +: 8] == c && !l[k]) begin
					off = 1'b1;
				end
			end
		end
	endfunction

	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_in
			input_filter u_filt (
				.i_ref_clk(i_ref_clk),
				.i_srst(i_srst),
				.i_ce(i_ce),
				.i_raw(i_contacts[gi]),
				.o_level(lvl[gi])
			);
			assign sels[8*gi +: 8] = sel_reg[gi];
		end
	endgenerate

	// APB decode.
	wire setup = i_psel && !i_penable;
	wire acc = i_psel && i_penable && o_pready;
	wire [7:0] widx = i_paddr - `A_SEL1;
	wire is_sel = (i_paddr[1:0] == 2'b00) && (i_paddr < `A_CTRL);
	wire is_ctrl = (i_paddr == `A_CTRL);
	wire is_stat = (i_paddr == `A_STAT);
	wire is_init = (i_paddr == `A_INIT);
	wire sel_bad = i_running || (i_pwdata[31:8] != 24'h000000) ||
		(i_pwdata[7:0] > `CODE_MAX);
	wire init_bad = i_running;
	wire wr_sel = acc && i_pwrite && is_sel && !sel_bad;
	wire wr_init = acc && i_pwrite && is_init && !init_bad;
	wire wr_ctrl = acc && i_pwrite && is_ctrl;

	// Decoded levels.
	wire code_lr = asg(sels, `C_LOCREM);
	wire lr_on = on(sels, lvl, `C_LOCREM);
	wire code_opt = asg(sels, `C_OPTSEL);
	wire opt_on = on(sels, lvl, `C_OPTSEL);
	wire blk = on(sels, lvl, `C_BLK_NO) || off(sels, lvl, `C_BLK_NC);
	wire hold = on(sels, lvl, `C_RHOLD);
	wire [1:0] fsrc = ctrl_reg[`F_FSRC];
	wire [1:0] rsrc = ctrl_reg[`F_RSRC];
	wire same_src = (fsrc == 2'b00) && (rsrc == 2'b00);
	wire run_src = o_local_mode ? i_panel_run : i_remote_run;
	wire [2:0] grp_cnt = {2'b00, asg(sels, `C_RHOLD)} +
		{2'b00, asg(sels, `C_UP) || asg(sels, `C_DOWN)} +
		{2'b00, asg(sels, `C_TRIMI) || asg(sels, `C_TRIMD)} +
		{2'b00, asg(sels, `C_SHOLD)};

	// Register write and read response.
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			sel_reg[0] <= `DEF_SEL1;
			sel_reg[1] <= `DEF_SEL2;
			sel_reg[2] <= `DEF_SEL3;
			sel_reg[3] <= `DEF_SEL4;
			sel_reg[4] <= `DEF_SEL5;
			sel_reg[5] <= `DEF_SEL6;
			ctrl_reg <= `CTRL_RST;
			o_prdata <= 32'h0000_0000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else if (i_ce) begin
			o_pready <= setup;
			if (setup) begin
				o_pslverr <= 1'b0;
				o_prdata <= 32'h0000_0000;
				if (is_sel) begin
					o_prdata <= {24'h000000, sels[8*widx[4:2] +: 8]};
					o_pslverr <= i_pwrite && sel_bad;
				end else if (is_ctrl) begin
					o_prdata <= ctrl_reg;
				end else if (is_stat) begin
					o_prdata <= {16'h0000, 2'b00, lvl, o_local_mode,
						o_use_option_ref, o_output_block, o_ramp_hold,
						o_setting_conflict_error,
						o_overheat_warning_message, vbusy, o_run};
				end else if (is_init) begin
					o_pslverr <= i_pwrite && init_bad;
				end else begin
					o_pslverr <= 1'b1;
				end
			end
			if (wr_sel) begin
				sel_reg[widx[4:2]] <= i_pwdata[7:0];
			end
			if (wr_ctrl) begin
				ctrl_reg <= i_pwdata;
			end
			if (wr_init) begin
				sel_reg[0] <= `DEF_SEL1;
				sel_reg[1] <= `DEF_SEL2;
				sel_reg[2] <= i_pwdata[0] ? `DEF3W_SEL3 : `DEF_SEL3;
				sel_reg[3] <= i_pwdata[0] ? `DEF3W_SEL4 : `DEF_SEL4;
				sel_reg[4] <= i_pwdata[0] ? `DEF3W_SEL5 : `DEF_SEL5;
				sel_reg[5] <= i_pwdata[0] ? `DEF3W_SEL6 : `DEF_SEL6;
			end
		end
	end

	// Source selection.
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_local_mode <= 1'b0;
			lr_in_reg <= 1'b0;
			opt_reg <= 1'b0;
			run_block_reg <= 1'b0;
			o_ref_from_panel <= 1'b0;
			o_run_from_panel <= 1'b0;
			o_use_option_ref <= 1'b0;
			o_run <= 1'b0;
		end else if (i_ce) begin
			if (!i_running) begin
				if (code_lr) begin
					o_local_mode <= lr_on;
				end else if (i_panel_lr_key) begin
					o_local_mode <= !o_local_mode;
				end
				opt_reg <= code_opt && opt_on;
			end
			// A run held across local to remote waits for a fresh edge.
			if (o_local_mode && !(code_lr ? lr_on : !i_panel_lr_key ||
				i_running) && i_remote_run &&
				!ctrl_reg[`F_LRRUN] && !same_src) begin
				run_block_reg <= 1'b1;
			end else if (!i_remote_run || o_local_mode) begin
				run_block_reg <= 1'b0;
			end
			o_ref_from_panel <= o_local_mode || fsrc == 2'b00;
			o_run_from_panel <= o_local_mode || rsrc == 2'b00;
			o_use_option_ref <= (fsrc == 2'b11) ||
				(!o_local_mode && opt_reg);
			o_run <= run_src && !(run_block_reg && !o_local_mode);
		end
	end

	// Output blocking with retained frequency.
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			blk_d_reg <= 1'b0;
			o_output_block <= 1'b0;
			o_speed_search <= 1'b0;
			o_retained_freq <= 16'h0000;
			o_volt_scale <= 8'hff;
		end else if (i_ce) begin
			blk_d_reg <= blk;
			o_output_block <= blk;
			o_speed_search <= blk_d_reg && !blk && o_run;
			if (!o_run) begin
				o_retained_freq <= 16'h0000;
			end else if (blk && !blk_d_reg) begin
				o_retained_freq <= i_out_freq;
			end
			o_volt_scale <= blk ? 8'h00 : vscale;
		end
	end

	volt_recovery u_vrec (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_blocked(blk),
		.i_time_us(ctrl_reg[`F_VRT]),
		.o_scale(vscale),
		.o_busy(vbusy)
	);

	// Ramp hold and frequency storage.
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			hold_d_reg <= 1'b0;
			run_d_reg <= 1'b0;
			o_ramp_hold <= 1'b0;
			o_hold_load <= 1'b0;
			o_hold_freq <= 16'h0000;
			o_nv_write <= 1'b0;
			o_nv_data <= 16'h0000;
		end else if (i_ce) begin
			hold_d_reg <= hold;
			run_d_reg <= o_run;
			o_ramp_hold <= hold && !i_stop_cmd;
			o_hold_load <= o_run && !run_d_reg && hold;
			if (o_run && !run_d_reg && hold) begin
				o_hold_freq <= ctrl_reg[`F_HSTORE] ? i_nv_freq :
					16'h0000;
			end else if (hold && !hold_d_reg) begin
				o_hold_freq <= i_out_freq;
			end
			o_nv_write <= hold && !hold_d_reg && o_run &&
				ctrl_reg[`F_HSTORE];
			if (hold && !hold_d_reg) begin
				o_nv_data <= i_out_freq;
			end
		end
	end

	// Messages and remaining decoded functions.
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_setting_conflict_error <= 1'b0;
			o_overheat_warning_message <= 1'b0;
			o_three_wire <= 1'b0;
			o_step_ref <= 4'h0;
			o_accel_sel <= 2'b00;
			o_fast_stop <= 1'b0;
			o_jog_fwd <= 1'b0;
			o_jog_rev <= 1'b0;
		end else if (i_ce) begin
			o_setting_conflict_error <= grp_cnt > 3'd1;
			o_overheat_warning_message <= on(sels, lvl, `C_OVHT);
			o_three_wire <= asg(sels, `C_3WIRE);
			o_step_ref <= {on(sels, lvl, `C_STEP1 + 8'h03),
				on(sels, lvl, `C_STEP1 + 8'h02),
				on(sels, lvl, `C_STEP1 + 8'h01),
				on(sels, lvl, `C_STEP1)};
			o_accel_sel <= {on(sels, lvl, `C_ACC2),
				on(sels, lvl, `C_ACC1)};
			o_fast_stop <= on(sels, lvl, `C_FSTOP) ||
				off(sels, lvl, `C_FSTOP_NC);
			o_jog_fwd <= on(sels, lvl, `C_JOGF);
			o_jog_rev <= on(sels, lvl, `C_JOGR);
		end
	end
endmodule

// ==== mfi_defs.vh ====
// Constants for the multi-function input decoder and the rule summary.
// How it works
// - six selectors, codes 0..77, locked while running
// - defaults 24,14,3,4,6,8; three-wire 0,3,4,6
// - code 1 on takes panel reference and run
// - local/remote input acts only while stopped
// - panel local/remote key ignored when code 1 used
// - held run ignored after local-to-remote unless selector 1
// - code 2 picks option card reference, stopped only
// - reference source 3 always uses option card
// - code 8 blocks when on, 9 when off
// - block keeps frequency, speed search on release
// - run off clears retained frequency
// - voltage ramps back over recovery time
// - code A freezes ramp while on
// - stop still stops during ramp hold
// - store selector 1 keeps and restarts held frequency
// - store selector 0 holds zero on run
// - conflicting hold-type groups raise conflict error
// - code B shows overheat warning, no fault
// - decode three-wire, steps, accel, fast stop, jog
// - both sources 0 make local and remote alike
`ifndef MFI_DEFS_VH
`define MFI_DEFS_VH
`define A_SEL1 8'h00
`define A_CTRL 8'h18
`define A_STAT 8'h1c
`define A_INIT 8'h20
`define CODE_MAX 8'h77
`define DEF_SEL1 8'h24
`define DEF_SEL2 8'h14
`define DEF_SEL3 8'h03
`define DEF_SEL4 8'h04
`define DEF_SEL5 8'h06
`define DEF_SEL6 8'h08
`define DEF3W_SEL3 8'h00
`define DEF3W_SEL4 8'h03
`define DEF3W_SEL5 8'h04
`define DEF3W_SEL6 8'h06
`define CTRL_RST 32'h0000_0000
`define F_FSRC 1:0
`define F_RSRC 3:2
`define F_LRRUN 4
`define F_HSTORE 5
`define F_VRT 31:16
`define C_3WIRE 8'h00
`define C_LOCREM 8'h01
`define C_OPTSEL 8'h02
`define C_STEP1 8'h03
`define C_ACC1 8'h07
`define C_BLK_NO 8'h08
`define C_BLK_NC 8'h09
`define C_RHOLD 8'h0a
`define C_OVHT 8'h0b
`define C_UP 8'h10
`define C_DOWN 8'h11
`define C_JOGF 8'h12
`define C_JOGR 8'h13
`define C_FSTOP 8'h15
`define C_FSTOP_NC 8'h17
`define C_ACC2 8'h1a
`define C_TRIMI 8'h1c
`define C_TRIMD 8'h1d
`define C_SHOLD 8'h1e
`define CLK_NS 5
`define DEB_US 10
`define DEB_CYC (`DEB_US * 1000 / `CLK_NS)
`define US_CYC 24'h0000c8
`endif

// ==== input_filter.v ====
// Synchroniser and stability filter for one external contact input.
`include "mfi_defs.vh"
module input_filter (
	// Clock and control
	input wire i_ref_clk,
	input wire i_srst,
	input wire i_ce,
	// Contact
	input wire i_raw,
	output reg o_level
);
	reg meta_reg;
	reg sync_reg;
	reg [15:0] cnt_reg;

	// The level is accepted only after it has been steady for the filter time.
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			cnt_reg <= 16'h0000;
			o_level <= 1'b0;
		end else if (i_ce) begin
			meta_reg <= i_raw;
			sync_reg <= meta_reg;
			if (sync_reg == o_level) begin
				cnt_reg <= 16'h0000;
			end else if (cnt_reg == `DEB_CYC - 1) begin
				cnt_reg <= 16'h0000;
				o_level <= sync_reg;
			end else begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end
endmodule

// ==== volt_recovery.v ====
// Output voltage recovery ramp from zero to full scale after a block.
`include "mfi_defs.vh"
module volt_recovery (
	// Clock and control
	input wire i_ref_clk,
	input wire i_srst,
	input wire i_ce,
	// Control
	input wire i_blocked,
	input wire [15:0] i_time_us,
	// Ramp
	output reg [7:0] o_scale,
	output reg o_busy
);
	reg [23:0] acc_reg;
	wire [23:0] thr;
	wire [23:0] acc_sum;

	assign thr = {8'h00, i_time_us} * `US_CYC;
	assign acc_sum = acc_reg + 24'h0000ff;

	// Each cycle adds 255 and a step is taken whenever the sum passes the
	// time in cycles, so 255 steps span the programmed time. Below about
	// 1.3 us the ramp is limited to one step per cycle.
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			acc_reg <= 24'h000000;
			o_scale <= 8'hff;
			o_busy <= 1'b0;
		end else if (i_ce) begin
			if (i_blocked) begin
				o_scale <= 8'h00;
				o_busy <= 1'b1;
				acc_reg <= 24'h000000;
			end else if (o_busy) begin
				if (i_time_us == 16'h0000 || o_scale == 8'hff) begin
					o_scale <= 8'hff;
					o_busy <= 1'b0;
				end else if (acc_sum >= thr) begin
					acc_reg <= acc_sum - thr;
					o_scale <= o_scale + 8'h01;
				end else begin
					acc_reg <= acc_sum;
				end
			end
		end
	end
endmodule

// ==== mfi_decoder_props.sv ====
// Port-level assertions for the multi-function input decoder.
module mfi_decoder_props (
	// Clock and control
	input wire i_ref_clk,
	input wire i_srst,
	input wire i_ce,
	// Bus
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [7:0] i_paddr,
	input wire [31:0] o_prdata,
	input wire o_pready,
	input wire o_pslverr,
	// Drive and outputs
	input wire i_running,
	input wire o_run,
	input wire o_local_mode,
	input wire o_output_block,
	input wire o_speed_search,
	input wire [15:0] o_retained_freq,
	input wire [7:0] o_volt_scale
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_srst || !i_ce);
	property p_ready;
		i_psel && !i_penable |=> o_pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready missing after setup");
	property p_ready_one;
		o_pready |=> !o_pready;
	endproperty
	a_ready_one: assert property (p_ready_one)
		else $error("ready held too long");
	property p_unmapped;
		i_psel && !i_penable && i_paddr > 8'h23 |=>
			o_pslverr && o_prdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");
	property p_lock;
		i_psel && !i_penable && i_pwrite && i_running &&
			i_paddr <= 8'h14 |=> o_pslverr;
	endproperty
	a_lock: assert property (p_lock)
		else $error("selector write accepted while running");
	property p_hold_lr;
		i_running [*3] |-> $stable(o_local_mode);
	endproperty
	a_hold_lr: assert property (p_hold_lr)
		else $error("local mode changed while running");
	property p_blk_volt;
		o_output_block [*2] |-> o_volt_scale == 8'h00;
	endproperty
	a_blk_volt: assert property (p_blk_volt)
		else $error("voltage present during block");
	property p_search;
		o_speed_search |-> !o_output_block &&
			($past(o_output_block) || $past(o_output_block, 2));
	endproperty
	a_search: assert property (p_search)
		else $error("speed search without block release");
	property p_search_one;
		o_speed_search |=> !o_speed_search;
	endproperty
	a_search_one: assert property (p_search_one)
		else $error("speed search longer than one cycle");
	property p_retain;
		!o_run [*2] |-> o_retained_freq == 16'h0000;
	endproperty
	a_retain: assert property (p_retain)
		else $error("retained frequency kept without run");
endmodule

// ==== contact_bank.sv ====
// Bouncing contact model for the six multi-function inputs.
module contact_bank (
	// Clock
	input wire logic i_ref_clk,
	// Wanted levels
	input wire logic [5:0] i_want,
	// Contacts
	output logic [5:0] o_raw
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] last_reg = 6'h00;
	logic [5:0] chg_reg = 6'h00;
	logic [2:0] bounce_reg = 3'h0;
	initial o_raw = 6'h00;
	// A change chatters for a few cycles before it settles.
	always @(posedge i_ref_clk) begin
		if (i_want != last_reg) begin
			last_reg <= i_want;
			chg_reg <= i_want ^ last_reg;
			bounce_reg <= 3'h5;
		end else if (bounce_reg != 3'h0) begin
			bounce_reg <= bounce_reg - 3'h1;
		end
		o_raw <= bounce_reg[0] ? (last_reg ^ chg_reg) : last_reg;
	end
endmodule

// ==== mfi_decoder_tb.sv ====
// Register and contact tests for the multi-function input decoder.
`include "mfi_defs.vh"
module mfi_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 0, i_srst = 1, i_psel = 0, i_penable = 0;
	logic i_pwrite = 0, i_panel_lr_key = 0, i_remote_run = 0;
	logic i_running = 0, i_stop_cmd = 0, i_ce = 1;
	logic [15:0] i_nv_freq = 16'h0555;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd;
	logic [15:0] i_out_freq = 16'h1234, o_retained_freq, o_hold_freq;
	logic [5:0] want = 6'h00, raw;
	logic [7:0] o_volt_scale;
	logic o_pready, o_pslverr, o_local_mode, o_ref_from_panel, er;
	logic o_run_from_panel, o_use_option_ref, o_run, o_output_block;
	logic o_speed_search, o_ramp_hold, o_setting_conflict_error;
	logic o_overheat_warning_message, o_three_wire;
	int err_total = 0, comparisons = 0;
	logic [7:0] defs [6] = '{`DEF_SEL1, `DEF_SEL2, `DEF_SEL3,
		`DEF_SEL4, `DEF_SEL5, `DEF_SEL6};
	logic [7:0] d3w [4] = '{`DEF3W_SEL3, `DEF3W_SEL4, `DEF3W_SEL5,
		`DEF3W_SEL6};
	logic [7:0] cfg [6] = '{`C_LOCREM, `C_BLK_NO, `C_RHOLD, `C_OVHT,
		`C_SHOLD, `C_OPTSEL};
	contact_bank u_contact_bank (.i_ref_clk(i_ref_clk), .i_want(want),
		.o_raw(raw));
	mfi_decoder u_mfi_decoder (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
		.i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_contacts(raw), .i_panel_lr_key(i_panel_lr_key),
		.i_panel_run(1'b0), .i_remote_run(i_remote_run),
		.i_stop_cmd(i_stop_cmd), .i_running(i_running),
		.i_out_freq(i_out_freq), .i_nv_freq(i_nv_freq),
		.o_local_mode(o_local_mode), .o_ref_from_panel(o_ref_from_panel),
		.o_run_from_panel(o_run_from_panel),
		.o_use_option_ref(o_use_option_ref), .o_run(o_run),
		.o_output_block(o_output_block), .o_speed_search(o_speed_search),
		.o_retained_freq(o_retained_freq), .o_volt_scale(o_volt_scale),
		.o_ramp_hold(o_ramp_hold), .o_hold_load(), .o_hold_freq(o_hold_freq),
		.o_nv_write(), .o_nv_data(),
		.o_setting_conflict_error(o_setting_conflict_error),
		.o_overheat_warning_message(o_overheat_warning_message),
		.o_three_wire(o_three_wire), .o_step_ref(), .o_accel_sel(),
		.o_fast_stop(), .o_jog_fwd(), .o_jog_rev());
	initial forever #2.5 i_ref_clk = ~i_ref_clk;
	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Starts just after a rising edge and returns one idle cycle later.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			err_total++;
			wrap_up();
		end
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_ref_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk("write error", er, e);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk("read data", rd, e);
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	initial begin
		wait_n(5);
		i_srst <= 1'b0;
		wait_n(1);
		for (int k = 0; k < 6; k++) rdc(8'(4 * k), defs[k]);
		rdc(`A_CTRL, `CTRL_RST);
		wr(`A_SEL1, 32'h0000_0078, 1'b1);
		rdc(`A_SEL1, `DEF_SEL1);
		wr(`A_SEL1, 32'h0000_0077, 1'b0);
		rdc(`A_SEL1, 32'h0000_0077);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped error", er, 1'b1);
		chk("unmapped data", rd, 32'h0000_0000);
		wr(`A_INIT, 32'h0000_0001, 1'b0);
		for (int k = 2; k < 6; k++) rdc(8'(4 * k), d3w[k - 2]);
		chk("three wire", o_three_wire, 1'b1);
		for (int k = 0; k < 6; k++) wr(8'(4 * k), cfg[k], 1'b0);
		wr(`A_CTRL, 32'h0005_0005, 1'b0);
		chk("conflict on", o_setting_conflict_error, 1'b1);
		chk("three wire off", o_three_wire, 1'b0);
		wr(8'h10, `C_STEP1, 1'b0);
		wait_n(1);
		chk("conflict off", o_setting_conflict_error, 1'b0);
		want <= 6'b001001;
		wait_n(2100);
		chk("local", o_local_mode, 1'b1);
		chk("ref panel", o_ref_from_panel, 1'b1);
		chk("run panel", o_run_from_panel, 1'b1);
		chk("overheat", o_overheat_warning_message, 1'b1);
		i_panel_lr_key <= 1'b1;
		wait_n(1);
		i_panel_lr_key <= 1'b0;
		wait_n(4);
		chk("key ignored", o_local_mode, 1'b1);
		i_running <= 1'b1;
		i_remote_run <= 1'b1;
		wait_n(1);
		wr(`A_SEL1, 32'h0000_0001, 1'b1);
		want <= 6'b000000;
		wait_n(2100);
		chk("local held", o_local_mode, 1'b1);
		chk("overheat off", o_overheat_warning_message, 1'b0);
		i_running <= 1'b0;
		wait_n(4);
		chk("remote", o_local_mode, 1'b0);
		chk("ref remote", o_ref_from_panel, 1'b0);
		chk("held run", o_run, 1'b0);
		i_remote_run <= 1'b0;
		wait_n(4);
		i_remote_run <= 1'b1;
		wait_n(4);
		chk("run again", o_run, 1'b1);
		want <= 6'b000010;
		wait_n(2100);
		chk("block", o_output_block, 1'b1);
		chk("block volt", o_volt_scale, 8'h00);
		chk("retained", o_retained_freq, 16'h1234);
		want <= 6'b000000;
		wait_n(3200);
		chk("unblock", o_output_block, 1'b0);
		chk("volt back", o_volt_scale, 8'hff);
		chk("kept", o_retained_freq, 16'h1234);
		i_remote_run <= 1'b0;
		wait_n(4);
		chk("cleared", o_retained_freq, 16'h0000);
		i_remote_run <= 1'b1;
		i_running <= 1'b1;
		i_out_freq <= 16'h0abc;
		want <= 6'b000100;
		wait_n(2100);
		chk("ramp hold", o_ramp_hold, 1'b1);
		chk("hold freq", o_hold_freq, 16'h0abc);
		i_stop_cmd <= 1'b1;
		wait_n(2);
		chk("hold stop", o_ramp_hold, 1'b0);
		i_stop_cmd <= 1'b0;
		i_remote_run <= 1'b0;
		wait_n(4);
		i_remote_run <= 1'b1;
		wait_n(4);
		chk("hold zero", o_hold_freq, 16'h0000);
		wr(`A_CTRL, 32'h0005_0025, 1'b0);
		i_remote_run <= 1'b0;
		wait_n(4);
		i_remote_run <= 1'b1;
		wait_n(4);
		chk("hold stored", o_hold_freq, 16'h0555);
		i_running <= 1'b0;
		i_remote_run <= 1'b0;
		wait_n(1);
		wr(8'h04, `C_BLK_NC, 1'b0);
		wait_n(4);
		chk("block nc", o_output_block, 1'b1);
		wr(`A_CTRL, 32'h0000_0007, 1'b0);
		wait_n(4);
		chk("option ref", o_use_option_ref, 1'b1);
		i_ce <= 1'b0;
		i_remote_run <= 1'b1;
		wait_n(4);
		chk("frozen run", o_run, 1'b0);
		i_ce <= 1'b1;
		wait_n(4);
		chk("thawed run", o_run, 1'b1);
		wrap_up();
	end
endmodule
bind mfi_decoder mfi_decoder_props u_mfi_decoder_props (
	.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .i_running(i_running), .o_run(o_run),
	.o_local_mode(o_local_mode), .o_output_block(o_output_block),
	.o_speed_search(o_speed_search), .o_retained_freq(o_retained_freq),
	.o_volt_scale(o_volt_scale));
